// File: design/cic_pkg.sv
// Shared constants, types and lookup tables for the capture input conditioner.
package cic_pkg;

  // ==========================================================================
  // Register map
  localparam int unsigned CIC_ADDR_W = 8;
  localparam logic [7:0] CIC_OFS_CTRL = 8'h00;
  localparam logic [7:0] CIC_OFS_ENABLE = 8'h04;
  localparam logic [7:0] CIC_OFS_STATUS = 8'h08;
  localparam logic [15:0] CIC_CTRL_RESET = 16'h0000;
  localparam logic [1:0] CIC_ENABLE_RESET = 2'h0;

  // ==========================================================================
  // Field positions
  localparam int unsigned CIC_CH_A_LSB = 0;
  localparam int unsigned CIC_CH_B_LSB = 8;
  localparam int unsigned CIC_CH_CFG_W = 8;
  localparam int unsigned CIC_EN_A_BIT = 0;
  localparam int unsigned CIC_EN_B_BIT = 1;
  localparam int unsigned CIC_ST_FILT_A_BIT = 0;
  localparam int unsigned CIC_ST_FILT_B_BIT = 1;
  localparam int unsigned CIC_ST_SRC_A_BIT = 2;
  localparam int unsigned CIC_ST_SRC_B_BIT = 3;

  // ==========================================================================
  // Timing
  localparam int unsigned CIC_DIV_W = 5;
  localparam int unsigned CIC_RATES = 6;
  localparam logic [3:0] CIC_FLT_OFF = 4'h0;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    CIC_MS_OUTPUT = 2'h0,
    CIC_MS_OWN = 2'h1,
    CIC_MS_NEIGHBOUR = 2'h2,
    CIC_MS_TRIGGER = 2'h3
  } cic_route_t;

  typedef struct packed {
    logic [3:0] flt;
    logic [1:0] psc;
    cic_route_t ms;
  } cic_chan_cfg_t;

  typedef struct packed {
    logic [3:0] need;
    logic [2:0] rate;
  } cic_flt_spec_t;

  // ==========================================================================
  // Filter code table: samples needed and sample rate index
  function automatic cic_flt_spec_t cic_flt_spec(input logic [3:0] code);
    cic_flt_spec_t s;
    s = '0;
    unique case (code)
      4'h0: s = '{need: 4'h0, rate: 3'h0};
      4'h1: s = '{need: 4'h2, rate: 3'h0};
      4'h2: s = '{need: 4'h4, rate: 3'h0};
      4'h3: s = '{need: 4'h8, rate: 3'h0};
      4'h4: s = '{need: 4'h6, rate: 3'h1};
      4'h5: s = '{need: 4'h8, rate: 3'h1};
      4'h6: s = '{need: 4'h6, rate: 3'h2};
      4'h7: s = '{need: 4'h8, rate: 3'h2};
      4'h8: s = '{need: 4'h6, rate: 3'h3};
      4'h9: s = '{need: 4'h8, rate: 3'h3};
      4'ha: s = '{need: 4'h5, rate: 3'h4};
      4'hb: s = '{need: 4'h6, rate: 3'h4};
      4'hc: s = '{need: 4'h8, rate: 3'h4};
      4'hd: s = '{need: 4'h5, rate: 3'h5};
      4'he: s = '{need: 4'h6, rate: 3'h5};
      4'hf: s = '{need: 4'h8, rate: 3'h5};
    endcase
    return s;
  endfunction

  // Edge count at which the prescaler fires
  function automatic logic [2:0] cic_psc_last(input logic [1:0] psc);
    logic [2:0] l;
    l = 3'h0;
    unique case (psc)
      2'h0: l = 3'h0;
      2'h1: l = 3'h1;
      2'h2: l = 3'h3;
      2'h3: l = 3'h7;
    endcase
    return l;
  endfunction

endpackage

// File: design/cic_noise_filter.sv
// Digital noise filter for one capture input.
`timescale 1ns/10ps
module cic_noise_filter
  import cic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input wire logic [3:0] code,
  input wire logic [CIC_RATES-1:0] rate_stb,
  // Signal
  input wire logic raw,
  output logic filtered
);

  cic_flt_spec_t spec;
  logic [3:0] need;
  logic smp_en;
  logic bypass;
  logic prev_q;
  logic [3:0] run_q;
  logic [3:0] run_d;
  logic out_q;

  // ==========================================================================
  // Sample rate and run length
  assign spec = cic_flt_spec(code);
  assign need = spec.need;
  assign bypass = (code == CIC_FLT_OFF);
  assign smp_en = rate_stb[spec.rate]; // [RL2]
  assign filtered = out_q;

  always_comb begin
    if (raw != prev_q) begin
      run_d = 4'h1; // [RL11]
    end else if (run_q >= need) begin
      run_d = need; // [RL2]
    end else begin
      run_d = run_q + 4'h1; // [RL2]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b0;
      run_q <= 4'h0;
    end else if (smp_en && !bypass) begin
      prev_q <= raw;
      run_q <= run_d;
    end
  end

  // ==========================================================================
  // Accepted level
  always_ff @(posedge clk) begin
    if (rst) begin
      out_q <= 1'b0;
    end else if (bypass) begin
      out_q <= raw; // [RL3]
    end else if (smp_en && run_d == need) begin
      out_q <= raw; // [RL2] [RL11]
    end
  end

  // ==========================================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_bypass;
    bypass |=> out_q == $past(raw);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass does not follow input"); // [RL3]

  property p_hold;
    !bypass && !smp_en |=> $stable(out_q);
  endproperty
  a_hold: assert property (p_hold) else $error("level moved between samples"); // [RL11]

  property p_change_cause;
    $changed(out_q) && !$past(bypass) |-> $past(smp_en) && $past(run_d) == $past(need);
  endproperty
  a_change_cause: assert property (p_change_cause) else $error("level taken early"); // [RL2]

  property p_two_samples;
    code == 4'h1 && smp_en && raw == prev_q && run_q == 4'h1 |=> out_q == $past(raw);
  endproperty
  a_two_samples: assert property (p_two_samples) else $error("two samples not taken"); // [RL3]

endmodule // cic_noise_filter

// File: design/cic_edge_prescaler.sv
// Capture edge prescaler for one channel.
`timescale 1ns/10ps
module cic_edge_prescaler
  import cic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic active,
  input wire logic [1:0] factor,
  // Signal
  input wire logic src,
  output logic capture
);

  logic src_q;
  logic edge_seen;
  logic [2:0] last;
  logic [2:0] cnt_q;
  logic cap_q;

  // ==========================================================================
  // Edge detect and count
  assign edge_seen = src & ~src_q;
  assign last = cic_psc_last(factor);
  assign capture = cap_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      src_q <= 1'b0;
    end else begin
      src_q <= src;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !active) begin
      cnt_q <= 3'h0; // [RL5]
      cap_q <= 1'b0;
    end else begin
      cap_q <= 1'b0;
      if (edge_seen) begin
        if (cnt_q >= last) begin
          cnt_q <= 3'h0; // [RL4]
          cap_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 3'h1;
        end
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_clear;
    !active |=> cnt_q == 3'h0 && !cap_q;
  endproperty
  a_clear: assert property (p_clear) else $error("prescaler not cleared"); // [RL5]

  property p_every_edge;
    active && factor == 2'h0 && edge_seen |=> cap_q;
  endproperty
  a_every_edge: assert property (p_every_edge) else $error("edge not captured"); // [RL4]

  property p_nth_edge;
    cap_q |-> $past(edge_seen) && $past(cnt_q) == $past(last);
  endproperty
  a_nth_edge: assert property (p_nth_edge) else $error("capture at wrong edge count"); // [RL4]

endmodule // cic_edge_prescaler

// File: design/cic_top.sv
// Capture input conditioning for two timer channels behind an APB slave.
// Contract
// RL1: Channel A filter setting lives in control word bits 7:4.
// RL2: Filter samples at chosen rate, accepts level after enough equal samples.
// RL3: Code 0 bypasses; other codes pick sample count and sample rate.
// RL4: Prescaler bits 3:2 capture every 1st, 2nd, 4th or 8th edge.
// RL5: Prescaler edge counter clears whenever the channel enable is low.
// RL6: Channel B filter at bits 15:12, prescaler at 11:10, same behaviour.
// RL7: Mode fields at 1:0 and 9:8 share storage with compare configuration.
// RL8: Software keeps bits 31:16 of the control word at reset value.
// RL9: Mode 00 output, 01 own input, 10 neighbour input, 11 internal trigger.
// RL10: Mode field writes are ignored while that channel is enabled.
// RL11: Filtered level holds until threshold; run restarts on any differing sample.
`timescale 1ns/10ps
module cic_top
  import cic_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [CIC_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Channel inputs
  input wire logic CH_A_RAW_INPUT,
  input wire logic CH_B_RAW_INPUT,
  input wire logic INTERNAL_TRIGGER_SOURCE,
  // Conditioned outputs
  output logic CH_A_FILTERED_OWN,
  output logic CH_B_FILTERED_OWN,
  output logic CH_A_CAPTURE,
  output logic CH_B_CAPTURE
);

  cic_chan_cfg_t cfg_a_q;
  cic_chan_cfg_t cfg_b_q;
  cic_chan_cfg_t wr_a;
  cic_chan_cfg_t wr_b;
  logic [1:0] active_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_en;
  logic hit_stat;
  logic mapped;
  logic wr_ctrl;
  logic wr_en;
  logic [CIC_DIV_W-1:0] div_q;
  logic [CIC_RATES-1:0] rate_stb;
  logic filt_a;
  logic filt_b;
  logic ch_a_selected_source;
  logic ch_b_selected_source;

  // ==========================================================================
  // APB decode
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE & pready_q;
  assign hit_ctrl = (PADDR == CIC_OFS_CTRL);
  assign hit_en = (PADDR == CIC_OFS_ENABLE);
  assign hit_stat = (PADDR == CIC_OFS_STATUS);
  assign mapped = hit_ctrl | hit_en | hit_stat;
  assign wr_ctrl = access & PWRITE & hit_ctrl;
  assign wr_en = access & PWRITE & hit_en;
  assign wr_a = cic_chan_cfg_t'(PWDATA[CIC_CH_A_LSB +: CIC_CH_CFG_W]);
  assign wr_b = cic_chan_cfg_t'(PWDATA[CIC_CH_B_LSB +: CIC_CH_CFG_W]);

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;

  // Zero wait: ready in the first access cycle
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= setup & ~mapped;
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_d[CIC_CH_A_LSB +: CIC_CH_CFG_W] = cfg_a_q; // [RL7]
      rd_d[CIC_CH_B_LSB +: CIC_CH_CFG_W] = cfg_b_q;
    end else if (hit_en) begin
      rd_d[CIC_EN_A_BIT] = active_q[0];
      rd_d[CIC_EN_B_BIT] = active_q[1];
    end else if (hit_stat) begin
      rd_d[CIC_ST_FILT_A_BIT] = filt_a;
      rd_d[CIC_ST_FILT_B_BIT] = filt_b;
      rd_d[CIC_ST_SRC_A_BIT] = ch_a_selected_source;
      rd_d[CIC_ST_SRC_B_BIT] = ch_b_selected_source;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      prdata_q <= rd_d;
    end else begin
      prdata_q <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Channel control word
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cfg_a_q <= cic_chan_cfg_t'(CIC_CTRL_RESET[CIC_CH_A_LSB +: CIC_CH_CFG_W]);
      cfg_b_q <= cic_chan_cfg_t'(CIC_CTRL_RESET[CIC_CH_B_LSB +: CIC_CH_CFG_W]);
    end else if (wr_ctrl) begin
      cfg_a_q.flt <= wr_a.flt; // [RL1]
      cfg_a_q.psc <= wr_a.psc; // [RL4]
      cfg_b_q.flt <= wr_b.flt; // [RL6]
      cfg_b_q.psc <= wr_b.psc; // [RL6]
      if (!active_q[0]) begin
        cfg_a_q.ms <= wr_a.ms; // [RL10] [RL7]
      end
      if (!active_q[1]) begin
        cfg_b_q.ms <= wr_b.ms; // [RL10] [RL7]
      end
    end
  end

  // ==========================================================================
  // Channel enable word
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      active_q <= CIC_ENABLE_RESET;
    end else if (wr_en) begin
      active_q[0] <= PWDATA[CIC_EN_A_BIT];
      active_q[1] <= PWDATA[CIC_EN_B_BIT];
    end
  end

  // ==========================================================================
  // Sample rate strobes from the dead-time clock divider
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end

  assign rate_stb[0] = 1'b1;
  for (genvar k = 1; k < CIC_RATES; k++) begin : g_rate
    assign rate_stb[k] = &div_q[k-1:0]; // [RL3]
  end

  // ==========================================================================
  // Noise filters
  cic_noise_filter u_filt_a (
    .clk(REF_CLK),
    .rst(RST),
    .code(cfg_a_q.flt), // [RL1]
    .rate_stb(rate_stb),
    .raw(CH_A_RAW_INPUT),
    .filtered(filt_a)
  );

  cic_noise_filter u_filt_b (
    .clk(REF_CLK),
    .rst(RST),
    .code(cfg_b_q.flt), // [RL6]
    .rate_stb(rate_stb),
    .raw(CH_B_RAW_INPUT),
    .filtered(filt_b)
  );

  assign CH_A_FILTERED_OWN = filt_a;
  assign CH_B_FILTERED_OWN = filt_b;

  // ==========================================================================
  // Capture source routing
  always_comb begin
    ch_a_selected_source = 1'b0;
    unique case (cfg_a_q.ms)
      CIC_MS_OUTPUT: ch_a_selected_source = 1'b0; // [RL9]
      CIC_MS_OWN: ch_a_selected_source = filt_a;
      CIC_MS_NEIGHBOUR: ch_a_selected_source = filt_b;
      CIC_MS_TRIGGER: ch_a_selected_source = INTERNAL_TRIGGER_SOURCE;
    endcase
  end

  always_comb begin
    ch_b_selected_source = 1'b0;
    unique case (cfg_b_q.ms)
      CIC_MS_OUTPUT: ch_b_selected_source = 1'b0; // [RL9]
      CIC_MS_OWN: ch_b_selected_source = filt_b;
      CIC_MS_NEIGHBOUR: ch_b_selected_source = filt_a;
      CIC_MS_TRIGGER: ch_b_selected_source = INTERNAL_TRIGGER_SOURCE;
    endcase
  end

  // ==========================================================================
  // Edge prescalers
  cic_edge_prescaler u_psc_a (
    .clk(REF_CLK),
    .rst(RST),
    .active(active_q[0]), // [RL5]
    .factor(cfg_a_q.psc), // [RL4]
    .src(ch_a_selected_source),
    .capture(CH_A_CAPTURE)
  );

  cic_edge_prescaler u_psc_b (
    .clk(REF_CLK),
    .rst(RST),
    .active(active_q[1]), // [RL5]
    .factor(cfg_b_q.psc), // [RL6]
    .src(ch_b_selected_source),
    .capture(CH_B_CAPTURE)
  );

  // ==========================================================================
  // Checks
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  property p_mode_locked;
    wr_ctrl && active_q[0] |=> cfg_a_q.ms == $past(cfg_a_q.ms);
  endproperty
  a_mode_locked: assert property (p_mode_locked) else $error("mode changed while active"); // [RL10]

  property p_mode_taken;
    wr_ctrl && !active_q[1] |=> cfg_b_q.ms == $past(PWDATA[9:8]);
  endproperty
  a_mode_taken: assert property (p_mode_taken) else $error("mode write lost"); // [RL10]

  property p_flt_a;
    wr_ctrl |=> cfg_a_q.flt == $past(PWDATA[7:4]) && cfg_a_q.psc == $past(PWDATA[3:2]);
  endproperty
  a_flt_a: assert property (p_flt_a) else $error("channel A fields misplaced"); // [RL1]

  property p_flt_b;
    wr_ctrl |=> cfg_b_q.flt == $past(PWDATA[15:12]) && cfg_b_q.psc == $past(PWDATA[11:10]);
  endproperty
  a_flt_b: assert property (p_flt_b) else $error("channel B fields misplaced"); // [RL6]

  property p_reserved;
    setup && hit_ctrl && !PWRITE |=> PRDATA[31:16] == 16'h0000 && PREADY;
  endproperty
  a_reserved: assert property (p_reserved) else $error("upper control bits not zero"); // [RL8]

  property p_output_mode;
    cfg_a_q.ms == CIC_MS_OUTPUT && $past(cfg_a_q.ms) == CIC_MS_OUTPUT |-> !CH_A_CAPTURE;
  endproperty
  a_output_mode: assert property (p_output_mode) else $error("capture in output mode"); // [RL9]

  property p_trigger_route;
    active_q[0] && cfg_a_q.psc == 2'h0 && cfg_a_q.ms == CIC_MS_TRIGGER && $stable(cfg_a_q.ms)
      && $rose(INTERNAL_TRIGGER_SOURCE) |=> CH_A_CAPTURE;
  endproperty
  a_trigger_route: assert property (p_trigger_route) else $error("trigger not routed"); // [RL9]

  property p_mode_locked_b;
    wr_ctrl && active_q[1] |=> cfg_b_q.ms == $past(cfg_b_q.ms);
  endproperty
  a_mode_locked_b: assert property (p_mode_locked_b) else $error("mode B moved"); // [RL10]

  property p_mode_taken_a;
    wr_ctrl && !active_q[0] |=> cfg_a_q.ms == $past(PWDATA[1:0]);
  endproperty
  a_mode_taken_a: assert property (p_mode_taken_a) else $error("mode A write lost"); // [RL10]

  property p_own_capture;
    active_q[0] && cfg_a_q.psc == 2'h0 && cfg_a_q.ms == CIC_MS_OWN && $stable(cfg_a_q.ms)
      && $rose(filt_a) |=> CH_A_CAPTURE;
  endproperty
  a_own_capture: assert property (p_own_capture) else $error("own edge not captured"); // [RL9]

  property p_cross_capture;
    active_q[1] && cfg_b_q.psc == 2'h0 && cfg_b_q.ms == CIC_MS_NEIGHBOUR && $stable(cfg_b_q.ms)
      && $rose(filt_a) |=> CH_B_CAPTURE;
  endproperty
  a_cross_capture: assert property (p_cross_capture) else $error("cross edge missed"); // [RL9]

endmodule // cic_top

// File: dv/cic_pin_model.sv
// Behavioural model of the pins that feed the two capture channels.
`timescale 1ns/10ps
module cic_pin_model (
  // Clock
  input wire logic clk,
  // Pin levels
  output logic raw_a,
  output logic raw_b,
  output logic trig
);
  // ==========================================================================
  // Idle levels
  initial begin
    raw_a = 1'b0;
    raw_b = 1'b0;
    trig = 1'b0;
  end

  // ==========================================================================
  // Pin drive, changed only right after a rising edge
  task automatic set_pin(input int pin, input logic level);
    case (pin)
      0: raw_a <= level;
      1: raw_b <= level;
      default: trig <= level;
    endcase
  endtask

  // High for len edges, then low for one edge
  task automatic pulse(input int pin, input int len);
    set_pin(pin, 1'b1);
    repeat (len) @(posedge clk);
    set_pin(pin, 1'b0);
    @(posedge clk);
  endtask

  // Hold a level for len edges
  task automatic hold(input int pin, input logic level, input int len);
    set_pin(pin, level);
    repeat (len) @(posedge clk);
  endtask
endmodule // cic_pin_model

// File: dv/testbench.sv
// Self-checking testbench for the capture input conditioner.
`timescale 1ns/10ps
module testbench import cic_pkg::*; ;
  // ==========================================================================
  // Signals
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [CIC_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic raw_a;
  logic raw_b;
  logic trig;
  logic [1:0] filt;
  logic [1:0] cap;
  int num_errors = 0;
  int check_count = 0;
  int cap_cnt [2] = '{0, 0};
  int hi_cnt [2] = '{0, 0};
  int need_tab [16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
  int shift_tab [16] = '{0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 4, 5, 5, 5};

  always #2.5 ref_clk = ~ref_clk;

  // ==========================================================================
  // Design and pins
  cic_top dut (
    .REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CH_A_RAW_INPUT(raw_a), .CH_B_RAW_INPUT(raw_b),
    .INTERNAL_TRIGGER_SOURCE(trig), .CH_A_FILTERED_OWN(filt[0]),
    .CH_B_FILTERED_OWN(filt[1]), .CH_A_CAPTURE(cap[0]), .CH_B_CAPTURE(cap[1])
  );

  cic_pin_model pins (.clk(ref_clk), .raw_a(raw_a), .raw_b(raw_b), .trig(trig));

  // ==========================================================================
  // Event counters
  always @(posedge ref_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (cap[i] === 1'b1) begin
        cap_cnt[i] <= cap_cnt[i] + 1;
      end
      if (filt[i] === 1'b1) begin
        hi_cnt[i] <= hi_cnt[i] + 1;
      end
    end
  end

  // ==========================================================================
  // Checking and closing
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================================
  // APB master
  task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
      output logic [31:0] rdata, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      n++;
      @(posedge ref_clk);
    end
    check("pready wait", 32'(n), 32'h0);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr_reg(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] r;
    logic e;
    apb_xfer(1'b1, addr, data, r, e);
  endtask

  task automatic rd_check(input string name, input logic [7:0] addr,
      input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb_xfer(1'b0, addr, 32'h0, r, e);
    check(name, r, exp);
    check("pslverr", 32'(e), 32'(exp_err));
  endtask

  // ==========================================================================
  // Watchdog
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    close_out();
  end

  // ==========================================================================
  // Tests
  initial begin
    int n;
    int d;
    int base;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    // Register reset values, unmapped place, reserved bits, mode lock
    rd_check("ctrl reset", CIC_OFS_CTRL, 32'(CIC_CTRL_RESET), 1'b0);
    rd_check("enable reset", CIC_OFS_ENABLE, 32'(CIC_ENABLE_RESET), 1'b0);
    rd_check("status reset", CIC_OFS_STATUS, 32'h0, 1'b0);
    rd_check("unmapped", 8'h0c, 32'h0, 1'b1);
    wr_reg(8'h0c, 32'h0000_ffff);
    wr_reg(CIC_OFS_CTRL, 32'h0000_ffff); // Reserved bits kept at reset value
    rd_check("ctrl upper", CIC_OFS_CTRL, 32'h0000_ffff, 1'b0);
    wr_reg(CIC_OFS_CTRL, 32'h0000_a5a5);
    rd_check("ctrl fields", CIC_OFS_CTRL, 32'h0000_a5a5, 1'b0);
    wr_reg(CIC_OFS_ENABLE, 32'h0000_0001);
    wr_reg(CIC_OFS_CTRL, 32'h0000_5a5a);
    rd_check("mode lock", CIC_OFS_CTRL, 32'h0000_5a59, 1'b0);
    wr_reg(CIC_OFS_ENABLE, 32'h0000_0000);
    wr_reg(CIC_OFS_CTRL, 32'h0000_0000);
    $display("test registers done");
    // Filter codes on both channels
    for (int ch = 0; ch < 2; ch++) begin
      for (int code = 0; code < 16; code++) begin
        n = need_tab[code];
        d = 1 << shift_tab[code];
        wr_reg(CIC_OFS_CTRL, 32'(code) << (4 + 8 * ch));
        pins.hold(ch, 1'b0, n * d + 4);
        if (n > 1) begin
          base = hi_cnt[ch];
          pins.pulse(ch, (n - 1) * d);
          if (d == 1) begin
            pins.pulse(ch, n - 1);
          end
          pins.hold(ch, 1'b0, 3);
          check("short run", 32'(hi_cnt[ch] - base), 32'h0);
        end
        pins.hold(ch, 1'b1, n * d + 2);
        check("accepted high", 32'(filt[ch]), 32'h1);
        pins.hold(ch, 1'b0, n * d + 2);
        check("accepted low", 32'(filt[ch]), 32'h0);
      end
    end
    $display("test filter done");
    // Source routing: own 1 edge, neighbour 2, trigger 3
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 0; m < 4; m++) begin
        wr_reg(CIC_OFS_ENABLE, 32'h0);
        wr_reg(CIC_OFS_CTRL, 32'(m) << (8 * ch));
        wr_reg(CIC_OFS_ENABLE, 32'h1 << ch);
        base = cap_cnt[ch];
        pins.pulse(ch, 2);
        repeat (2) pins.pulse(1 - ch, 2);
        repeat (3) pins.pulse(2, 2);
        pins.hold(2, 1'b0, 3);
        check("route captures", 32'(cap_cnt[ch] - base), 32'(m));
        if (m == 3) begin
          pins.hold(2, 1'b1, 2);
          rd_check("status source", CIC_OFS_STATUS, 32'h4 << ch, 1'b0);
          pins.hold(2, 1'b0, 2);
        end
      end
    end
    $display("test routing done");
    // Prescaler factors
    for (int ch = 0; ch < 2; ch++) begin
      for (int p = 0; p < 4; p++) begin
        wr_reg(CIC_OFS_ENABLE, 32'h0);
        wr_reg(CIC_OFS_CTRL, 32'(3 | (p << 2)) << (8 * ch));
        wr_reg(CIC_OFS_ENABLE, 32'h1 << ch);
        base = cap_cnt[ch];
        repeat (16) pins.pulse(2, 1);
        pins.hold(2, 1'b0, 3);
        check("prescaled", 32'(cap_cnt[ch] - base), 32'(16 >> p));
      end
    end
    // Edge counter cleared by disable
    wr_reg(CIC_OFS_ENABLE, 32'h0);
    wr_reg(CIC_OFS_CTRL, 32'h0000_000b);
    wr_reg(CIC_OFS_ENABLE, 32'h1);
    base = cap_cnt[0];
    repeat (3) pins.pulse(2, 1);
    wr_reg(CIC_OFS_ENABLE, 32'h0);
    repeat (2) pins.pulse(2, 1);
    wr_reg(CIC_OFS_ENABLE, 32'h1);
    repeat (3) pins.pulse(2, 1);
    pins.hold(2, 1'b0, 3);
    check("counter cleared", 32'(cap_cnt[0] - base), 32'h0);
    pins.pulse(2, 1);
    pins.hold(2, 1'b0, 3);
    check("fourth edge", 32'(cap_cnt[0] - base), 32'h1);
    $display("test prescaler done");
    close_out();
  end
endmodule // testbench
